// >>> rtl/fsi_pkg.sv
package fsi_pkg;

   // =========================================================
   // widths
   localparam int FSI_DATA_W = 32;
   localparam int FSI_ADR_W = 8;
   localparam int FSI_IRQ_W = 3;

   // =========================================================
   // register offsets (byte addresses)
   localparam logic [7:0] FSI_ADR_CTRL = 8'h00;
   localparam logic [7:0] FSI_ADR_STATUS = 8'h04;
   localparam logic [7:0] FSI_ADR_RESULT_C = 8'h08;
   localparam logic [7:0] FSI_ADR_TEMP_LO = 8'h0c;
   localparam logic [7:0] FSI_ADR_TEMP_HI = 8'h10;
   localparam logic [7:0] FSI_ADR_IRQ_STATUS = 8'h14;
   localparam logic [7:0] FSI_ADR_IRQ_CLEAR = 8'h18;
   localparam logic [7:0] FSI_ADR_IRQ_ENABLE = 8'h1c;

   // =========================================================
   // control register fields
   localparam int FSI_CTRL_SRC_LSB = 0;
   localparam int FSI_CTRL_PARITY_PER_BYTE_SELECT = 2;
   localparam int FSI_CTRL_EDGE = 3;
   localparam int FSI_CTRL_I6 = 4;
   localparam int FSI_CTRL_OP_LSB = 5;
   localparam int FSI_CTRL_TEMP_EN = 7;
   localparam int FSI_CTRL_W = 8;
   localparam logic [7:0] FSI_CTRL_RESET = 8'h00;

   // =========================================================
   // status register fields
   localparam int FSI_ST_EQ = 0;
   localparam int FSI_ST_GT = 1;
   localparam int FSI_ST_CHAINED_EXCEPTION_FLAG = 2;

   // =========================================================
   // interrupt bits, same layout in status, clear and enable
   localparam int FSI_IRQ_CHAINED_EXCEPTION_FLAG = 0;
   localparam int FSI_IRQ_CLOAD = 1;
   localparam int FSI_IRQ_TEMP = 2;
   localparam logic [2:0] FSI_IRQ_RESET = 3'h0;

   localparam logic [31:0] FSI_WORD_RESET = 32'h0000_0000;
   localparam logic [63:0] FSI_TEMP_RESET = 64'h0000_0000_0000_0000;

   // =========================================================
   // operand source configuration
   typedef enum logic [1:0] {
      FSI_SRC_BUSES = 2'b00,
      FSI_SRC_TEMP_A = 2'b01,
      FSI_SRC_TEMP_AB = 2'b10,
      FSI_SRC_TEMP_B = 2'b11
   } fsi_src_e;

   // =========================================================
   // alu operations
   typedef enum logic [1:0] {
      FSI_OP_COMPARE = 2'b00,
      FSI_OP_ADD = 2'b01,
      FSI_OP_SUB = 2'b10,
      FSI_OP_CHAIN = 2'b11
   } fsi_op_e;

endpackage

// >>> rtl/fsi_parity.sv
`timescale 1ns/1ps
module fsi_parity
   import fsi_pkg::*;
#(
   parameter int WIDTH = FSI_DATA_W
) (
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic load,
   input wire logic per_byte,
   input wire logic [WIDTH-1:0] data,
   output logic [WIDTH/8-1:0] parity
);

   initial begin
      if (WIDTH % 8 != 0 || WIDTH < 8) begin
         $error("fsi_parity: WIDTH must be a whole number of bytes");
      end
   end

   logic [WIDTH/8-1:0] byte_par;
   logic [WIDTH/8-1:0] next_parity;

   // =========================================================
   // even parity, per byte or over the whole word
   always_comb begin
      for (int i = 0; i < WIDTH/8; i++) begin
         byte_par[i] = ^data[i*8 +: 8];
      end
      // RULE4 byte mode
      // RULE5 word mode, bit 0 only
      next_parity = per_byte ? byte_par : {{(WIDTH/8-1){1'b0}}, ^data};
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         parity <= '0;
      end else if (load) begin
         parity <= next_parity;
      end
   end

endmodule

// >>> rtl/fsi_top.sv
// Overview of operation
// RULE1 - during a compare the equal flag goes high when both operands match.
// RULE2 - for any other operation the equal flag goes high when the result is zero.
// RULE3 - the greater flag goes high when the first operand exceeds the second.
// RULE4 - with byte parity selected each bus gets four parity bits, one per byte.
// RULE5 - with byte parity off each bus gets one parity bit over the whole word.
// RULE6 - a chained exception raises the exception flag, naming the multiplier when bit six is low.
// RULE7 - with bit six high the exception flag names the adder as the source.
// RULE8 - all datapath registers follow the master clock except the result register on its own clock.
// RULE9 - the temporary register loads on the master rising edge, or the falling one when selected.
// RULE10 - a two-bit setting picks each operand register's source from the two buses or the temporary.
// RULE11 - the first bus can be latched into the 64-bit temporary register.
// RULE12 - the first bus can also load an operand register directly.
// RULE13 - the second bus behaves the same way as the first.
// RULE14 - comparison and exception flags update on the master clock together with their result.
`timescale 1ns/1ps
module fsi_top
   import fsi_pkg::*;
#(
   parameter int DATA_W = FSI_DATA_W
) (
   input wire logic sys_clk,
   input wire logic rst,
   // wishbone classic slave
   input wire logic wb_cyc,
   input wire logic wb_stb,
   input wire logic wb_we,
   input wire logic [FSI_ADR_W-1:0] wb_adr,
   input wire logic [3:0] wb_sel,
   input wire logic [31:0] wb_dat_w,
   output logic [31:0] wb_dat_r,
   output logic wb_ack,
   // device pins
   input wire logic master_clock,
   input wire logic result_register_clock,
   input wire logic [DATA_W-1:0] input_bus_first,
   input wire logic [DATA_W-1:0] input_bus_second,
   output logic operands_equal_or_zero,
   output logic first_greater_flag,
   output logic chained_exception_flag,
   output logic [DATA_W/8-1:0] parity_first,
   output logic [DATA_W/8-1:0] parity_second,
   output logic [DATA_W-1:0] result_c,
   output logic irq
);

   initial begin
      if (DATA_W != FSI_DATA_W) begin
         $error("fsi_top: DATA_W must be 32, registers hold one bus word");
      end
   end

   // =========================================================
   // functions
   function automatic logic [31:0] merge_sel(input logic [31:0] old_v, input logic [31:0] new_v,
                                             input logic [3:0] sel);
      logic [31:0] r;
      r = old_v;
      for (int i = 0; i < 4; i++) begin
         if (sel[i]) begin
            r[i*8 +: 8] = new_v[i*8 +: 8];
         end
      end
      return r;
   endfunction

   function automatic logic rise_of(input logic now_v, input logic old_v);
      return now_v & ~old_v;
   endfunction

   // =========================================================
   // clock pin synchronisers
   // the master and result clocks arrive as pins; sampling them keeps one clock
   // domain at the cost of needing them well below half of sys_clk
   logic [2:0] mclk_sync;
   logic [2:0] cclk_sync;

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         mclk_sync <= 3'h0;
         cclk_sync <= 3'h0;
      end else begin
         mclk_sync <= {mclk_sync[1:0], master_clock};
         cclk_sync <= {cclk_sync[1:0], result_register_clock};
      end
   end

   wire mclk_rise = rise_of(mclk_sync[1], mclk_sync[2]);
   wire mclk_fall = rise_of(mclk_sync[2], mclk_sync[1]);
   wire cclk_rise = rise_of(cclk_sync[1], cclk_sync[2]);

   // =========================================================
   // software registers
   logic [FSI_CTRL_W-1:0] ctrl;
   logic [FSI_IRQ_W-1:0] irq_status;
   logic [FSI_IRQ_W-1:0] irq_enable;

   wire bus_req = wb_cyc & wb_stb & ~wb_ack;
   wire wr_fire = bus_req & wb_we;
   wire hit_ctrl = wb_adr == FSI_ADR_CTRL;
   wire hit_clear = wb_adr == FSI_ADR_IRQ_CLEAR;
   wire hit_enable = wb_adr == FSI_ADR_IRQ_ENABLE;

   wire [31:0] ctrl_merged = merge_sel({24'h00_0000, ctrl}, wb_dat_w, wb_sel);
   wire [31:0] enable_merged = merge_sel({29'h0, irq_enable}, wb_dat_w, wb_sel);
   wire [31:0] clear_word = merge_sel(32'h0000_0000, wb_dat_w, wb_sel);
   wire [FSI_IRQ_W-1:0] irq_clear = (wr_fire & hit_clear) ? clear_word[FSI_IRQ_W-1:0] : '0;

   wire [1:0] src_sel = ctrl[FSI_CTRL_SRC_LSB +: 2];
   wire byte_parity = ctrl[FSI_CTRL_PARITY_PER_BYTE_SELECT];
   wire temp_edge_sel = ctrl[FSI_CTRL_EDGE];
   wire instruction_bit_six = ctrl[FSI_CTRL_I6];
   wire [1:0] op_sel = ctrl[FSI_CTRL_OP_LSB +: 2];
   wire temp_enable = ctrl[FSI_CTRL_TEMP_EN];

   // =========================================================
   // temporary register
   logic [2*DATA_W-1:0] temp_reg;

   // RULE9 edge choice
   wire temp_edge = temp_edge_sel ? mclk_fall : mclk_rise;
   wire temp_fire = temp_enable & temp_edge;

   // RULE11 first bus to low word
   // RULE13 second bus to high word
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         temp_reg <= FSI_TEMP_RESET;
      end else if (temp_fire) begin
         temp_reg <= {input_bus_second, input_bus_first};
      end
   end

   // =========================================================
   // operand registers
   logic [DATA_W-1:0] operand_reg_first;
   logic [DATA_W-1:0] operand_reg_second;
   wire [DATA_W-1:0] temp_lo = temp_reg[DATA_W-1:0];
   wire [DATA_W-1:0] temp_hi = temp_reg[2*DATA_W-1:DATA_W];

   // RULE10 source select
   // RULE12 direct load from the first bus
   wire a_from_temp = (src_sel == FSI_SRC_TEMP_A) || (src_sel == FSI_SRC_TEMP_AB);
   wire b_from_temp = (src_sel == FSI_SRC_TEMP_AB) || (src_sel == FSI_SRC_TEMP_B);
   wire [DATA_W-1:0] next_operand_first = a_from_temp ? temp_lo : input_bus_first;
   // RULE13 direct load from the second bus
   wire [DATA_W-1:0] next_operand_second = b_from_temp ? temp_hi : input_bus_second;

   // RULE8 master clock edge
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         operand_reg_first <= FSI_WORD_RESET;
         operand_reg_second <= FSI_WORD_RESET;
      end else if (mclk_rise) begin
         operand_reg_first <= next_operand_first;
         operand_reg_second <= next_operand_second;
      end
   end

   // =========================================================
   // input parity
   fsi_parity #(
      .WIDTH(DATA_W)
   ) u_parity_first (
      .sys_clk(sys_clk),
      .rst(rst),
      .load(mclk_rise),
      .per_byte(byte_parity),
      .data(input_bus_first),
      .parity(parity_first)
   );

   fsi_parity #(
      .WIDTH(DATA_W)
   ) u_parity_second (
      .sys_clk(sys_clk),
      .rst(rst),
      .load(mclk_rise),
      .per_byte(byte_parity),
      .data(input_bus_second),
      .parity(parity_second)
   );

   // =========================================================
   // alu and multiplier, unsigned integer
   wire [2*DATA_W-1:0] product = operand_reg_first * operand_reg_second;
   wire [DATA_W:0] sum_add = {1'b0, operand_reg_first} + {1'b0, operand_reg_second};
   wire [DATA_W:0] sum_sub = {1'b0, operand_reg_first} - {1'b0, operand_reg_second};
   // chained: product low word plus first operand
   wire [DATA_W:0] sum_chain = {1'b0, product[DATA_W-1:0]} + {1'b0, operand_reg_first};
   wire mul_overflow = |product[2*DATA_W-1:DATA_W];
   wire is_compare = op_sel == FSI_OP_COMPARE;
   wire is_chain = op_sel == FSI_OP_CHAIN;

   logic [DATA_W-1:0] next_result;
   logic alu_overflow;

   always_comb begin
      unique case (op_sel)
         FSI_OP_COMPARE: begin
            next_result = sum_sub[DATA_W-1:0];
            alu_overflow = 1'b0;
         end
         FSI_OP_ADD: begin
            next_result = sum_add[DATA_W-1:0];
            alu_overflow = sum_add[DATA_W];
         end
         FSI_OP_SUB: begin
            next_result = sum_sub[DATA_W-1:0];
            alu_overflow = sum_sub[DATA_W];
         end
         FSI_OP_CHAIN: begin
            next_result = sum_chain[DATA_W-1:0];
            alu_overflow = sum_chain[DATA_W];
         end
      endcase
   end

   // RULE1 compare equality
   // RULE2 zero detect otherwise
   wire next_equal = is_compare ? (operand_reg_first == operand_reg_second) : (next_result == '0);
   // RULE3 greater than
   wire next_greater = operand_reg_first > operand_reg_second;
   // RULE6 multiplier source when bit six low
   // RULE7 adder source when bit six high
   wire next_chained_exception_flag = is_chain & (instruction_bit_six ? alu_overflow : mul_overflow);

   // =========================================================
   // result and status, one master edge after the operands
   logic [DATA_W-1:0] result_reg;

   // RULE14 flags beside their result
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         result_reg <= FSI_WORD_RESET;
         operands_equal_or_zero <= 1'b0;
         first_greater_flag <= 1'b0;
         chained_exception_flag <= 1'b0;
      end else if (mclk_rise) begin
         result_reg <= next_result;
         operands_equal_or_zero <= next_equal;
         first_greater_flag <= next_greater;
         chained_exception_flag <= next_chained_exception_flag;
      end
   end

   // RULE8 result register on its own clock
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         result_c <= FSI_WORD_RESET;
      end else if (cclk_rise) begin
         result_c <= result_reg;
      end
   end

   // =========================================================
   // interrupts; a new event beats a clear in the same cycle
   wire [FSI_IRQ_W-1:0] irq_event = {temp_fire, cclk_rise, mclk_rise & next_chained_exception_flag};
   wire [FSI_IRQ_W-1:0] next_irq_status = (irq_status & ~irq_clear) | irq_event;

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         irq_status <= FSI_IRQ_RESET;
         irq <= 1'b0;
      end else begin
         irq_status <= next_irq_status;
         irq <= |(irq_status & irq_enable);
      end
   end

   // =========================================================
   // control writes
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         ctrl <= FSI_CTRL_RESET;
         irq_enable <= FSI_IRQ_RESET;
      end else if (wr_fire) begin
         if (hit_ctrl) begin
            ctrl <= ctrl_merged[FSI_CTRL_W-1:0];
         end
         if (hit_enable) begin
            irq_enable <= enable_merged[FSI_IRQ_W-1:0];
         end
      end
   end

   // =========================================================
   // read mux; unmapped and write-only offsets read zero
   logic [31:0] read_word;

   always_comb begin
      read_word = 32'h0000_0000;
      case (wb_adr)
         FSI_ADR_CTRL: read_word = {24'h00_0000, ctrl};
         FSI_ADR_STATUS: read_word = {29'h0, chained_exception_flag, first_greater_flag,
                                      operands_equal_or_zero};
         FSI_ADR_RESULT_C: read_word = result_c;
         FSI_ADR_TEMP_LO: read_word = temp_lo;
         FSI_ADR_TEMP_HI: read_word = temp_hi;
         FSI_ADR_IRQ_STATUS: read_word = {29'h0, irq_status};
         FSI_ADR_IRQ_ENABLE: read_word = {29'h0, irq_enable};
         default: read_word = 32'h0000_0000;
      endcase
   end

   // every access is answered one cycle after it starts
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         wb_ack <= 1'b0;
         wb_dat_r <= FSI_WORD_RESET;
      end else begin
         wb_ack <= bus_req;
         if (bus_req && !wb_we) begin
            wb_dat_r <= read_word;
         end
      end
   end

endmodule

// >>> test/fsi_top_checker.sv
`timescale 1ns/1ps
module fsi_top_checker
   import fsi_pkg::*;
#(
   parameter int DATA_W = FSI_DATA_W
) (
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic wb_cyc,
   input wire logic wb_stb,
   input wire logic [31:0] wb_dat_r,
   input wire logic wb_ack,
   input wire logic master_clock,
   input wire logic result_register_clock,
   input wire logic [DATA_W-1:0] input_bus_first,
   input wire logic [DATA_W-1:0] input_bus_second,
   input wire logic operands_equal_or_zero,
   input wire logic first_greater_flag,
   input wire logic chained_exception_flag,
   input wire logic [DATA_W/8-1:0] parity_first,
   input wire logic [DATA_W/8-1:0] parity_second,
   input wire logic [DATA_W-1:0] result_c,
   input wire logic irq
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (rst);
   // =========================================
   // cycles since each pin clock rose, saturating
   logic m_q, c_q;
   logic [2:0] m_cnt, c_cnt;
   always_ff @(posedge sys_clk) begin
      m_q <= master_clock;
      c_q <= result_register_clock;
      m_cnt <= (rst || (master_clock && !m_q)) ? 3'h0 : m_cnt + {2'h0, m_cnt != 3'h7};
      c_cnt <= (rst || (result_register_clock && !c_q)) ? 3'h0 : c_cnt + {2'h0, c_cnt != 3'h7};
   end
   // mode is not visible here, so either layout is accepted
   function automatic logic par_ok(input logic [DATA_W/8-1:0] p, input logic [DATA_W-1:0] d);
      logic [DATA_W/8-1:0] by;
      for (int i = 0; i < DATA_W / 8; i++) by[i] = ^d[8*i+:8];
      return p == by || p == (DATA_W/8)'(^d);
   endfunction
   sequence s_request;
      wb_cyc && wb_stb && !wb_ack;
   endsequence
   sequence s_master_rise;
      $rose(master_clock);
   endsequence
   // =========================================
   // properties
   a_ack_next_cycle: assert property (s_request |=> wb_ack)
      else $error("request not answered one cycle later");
   a_ack_one_pulse: assert property (wb_ack |=> !wb_ack)
      else $error("ack longer than one cycle");
   a_rdata_with_ack: assert property ($changed(wb_dat_r) |-> wb_ack)
      else $error("read data moved without ack");
   a_parity_first_bus: assert property (s_master_rise |-> ##4 par_ok(parity_first, $past(input_bus_first, 4)))
      else $error("first bus parity wrong");
   a_parity_second_bus: assert property (s_master_rise |-> ##4 par_ok(parity_second, $past(input_bus_second, 4)))
      else $error("second bus parity wrong");
   a_flags_follow_master: assert property ((m_cnt >= 3'h5) |-> $stable({operands_equal_or_zero, first_greater_flag, chained_exception_flag}))
      else $error("status flags moved away from a master rise");
   a_result_own_clock: assert property ((c_cnt >= 3'h5) |-> $stable(result_c))
      else $error("result register moved away from its clock");
   a_reset_clears: assert property ($fell(rst) |-> result_c == '0 && !irq && !wb_ack && !operands_equal_or_zero
      && !first_greater_flag && !chained_exception_flag && parity_first == '0 && parity_second == '0)
      else $error("outputs not cleared by reset");
endmodule

// >>> test/fsi_ctrl_model.sv
`timescale 1ns/1ps
module fsi_ctrl_model (
   input wire logic sys_clk,
   output logic master_clock,
   output logic result_register_clock,
   output logic [31:0] input_bus_first,
   output logic [31:0] input_bus_second
);
   initial begin
      master_clock = 1'b0;
      result_register_clock = 1'b0;
      input_bus_first = 32'h0000_0000;
      input_bus_second = 32'h0000_0000;
   end
   // =========================================
   // one master period, data held over the rise
   task automatic step(input logic [31:0] a, input logic [31:0] b, input int hold);
      input_bus_first <= a;
      input_bus_second <= b;
      repeat (3) @(posedge sys_clk);
      master_clock <= 1'b1;
      repeat (hold) @(posedge sys_clk);
      // stale data is not kept: the buses turn to its inverse at the fall
      master_clock <= 1'b0;
      input_bus_first <= ~a;
      input_bus_second <= ~b;
      repeat (hold) @(posedge sys_clk);
   endtask
   task automatic pulse_c(input int hold);
      result_register_clock <= 1'b1;
      repeat (hold) @(posedge sys_clk);
      result_register_clock <= 1'b0;
      repeat (hold) @(posedge sys_clk);
   endtask
endmodule

// >>> test/fsi_top_test.sv
`timescale 1ns/1ps
module fsi_top_test
   import fsi_pkg::*;
;
   logic sys_clk = 1'b0;
   logic rst = 1'b1;
   logic wb_cyc = 1'b0;
   logic wb_stb = 1'b0;
   logic wb_we = 1'b0;
   logic [7:0] wb_adr = 8'h00;
   logic [3:0] wb_sel = 4'hf;
   logic [31:0] wb_dat_w = 32'h0000_0000;
   logic [31:0] wb_dat_r, result_c, input_bus_first, input_bus_second, a, b, q;
   logic wb_ack, master_clock, result_register_clock, irq;
   logic operands_equal_or_zero, first_greater_flag, chained_exception_flag;
   logic [3:0] parity_first, parity_second;
   logic [34:0] obs;
   logic [7:0] regs [9] = '{FSI_ADR_CTRL, FSI_ADR_STATUS, FSI_ADR_RESULT_C, FSI_ADR_TEMP_LO, FSI_ADR_TEMP_HI,
      FSI_ADR_IRQ_STATUS, FSI_ADR_IRQ_CLEAR, FSI_ADR_IRQ_ENABLE, 8'h20};
   int err_count = 0;
   int checks_done = 0;
   assign obs = {chained_exception_flag, first_greater_flag, operands_equal_or_zero, result_c};
   always #20 sys_clk = ~sys_clk;
   fsi_top dut (.sys_clk, .rst, .wb_cyc, .wb_stb, .wb_we, .wb_adr, .wb_sel, .wb_dat_w, .wb_dat_r, .wb_ack,
      .master_clock, .result_register_clock, .input_bus_first, .input_bus_second, .operands_equal_or_zero,
      .first_greater_flag, .chained_exception_flag, .parity_first, .parity_second, .result_c, .irq);
   fsi_ctrl_model pm (.sys_clk, .master_clock, .result_register_clock, .input_bus_first, .input_bus_second);
   // =========================================
   // expectations and reporting
   function automatic logic [34:0] calc(input logic [1:0] op, input logic i6, input logic [31:0] a,
      input logic [31:0] b);
      logic [63:0] p;
      logic [32:0] s;
      logic [31:0] r;
      p = {32'h0, a} * {32'h0, b};
      s = {1'b0, p[31:0]} + {1'b0, a};
      r = (op == FSI_OP_ADD) ? a + b : (op == FSI_OP_CHAIN) ? s[31:0] : a - b;
      return {op == FSI_OP_CHAIN && (i6 ? s[32] : p[63:32] != 0), a > b, (op == FSI_OP_COMPARE) ? a == b : r == 0, r};
   endfunction
   function automatic logic [3:0] par(input logic [31:0] d, input logic byp);
      return byp ? {^d[31:24], ^d[23:16], ^d[15:8], ^d[7:0]} : {3'h0, ^d};
   endfunction
   task automatic chk(input logic [34:0] seen, input logic [34:0] exp);
      checks_done++;
      if (seen !== exp) begin
         err_count++;
         $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic stop_test();
      $display("checks %0d mismatches %0d", checks_done, err_count);
      if (err_count == 0 && checks_done > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   // =========================================
   // bus cycles
   task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] d);
      int n;
      n = 0;
      wb_cyc <= 1'b1;
      wb_stb <= 1'b1;
      wb_we <= we;
      wb_adr <= adr;
      wb_dat_w <= d;
      do begin
         @(posedge sys_clk);
         n++;
      end while (wb_ack !== 1'b1 && n < 16);
      if (wb_ack !== 1'b1) begin
         err_count++;
         $display("CHECK FAILED at %0t: bus gave no answer", $time);
         stop_test();
      end else begin
         q = wb_dat_r;
         wb_cyc <= 1'b0;
         wb_stb <= 1'b0;
         @(posedge sys_clk);
      end
   endtask
   task automatic wr(input logic [7:0] adr, input logic [31:0] d);
      wb(1'b1, adr, d);
   endtask
   task automatic rd_chk(input logic [7:0] adr, input logic [31:0] exp);
      wb(1'b0, adr, 32'h0000_0000);
      chk({3'h0, q}, {3'h0, exp});
   endtask
   // =========================================
   // scenarios
   task automatic run(input logic [1:0] op, input logic i6, input logic byp, input logic [31:0] a, input logic [31:0] b);
      int h;
      logic [34:0] e;
      h = 4 + $urandom_range(3);
      e = calc(op, i6, a, b);
      // both operands straight from the buses
      wr(FSI_ADR_CTRL, {24'h0, 1'b0, op, i6, 1'b0, byp, FSI_SRC_BUSES});
      pm.step(a, b, h);
      pm.step(a, b, h);
      chk({31'h0, parity_first}, {31'h0, par(a, byp)});
      chk({31'h0, parity_second}, {31'h0, par(b, byp)});
      pm.pulse_c(h);
      chk(obs, e);
      // status holds only the three flags, not the result word
      rd_chk(FSI_ADR_STATUS, {29'h0, e[34:32]});
   endtask
   task automatic temp_case(input logic edge_sel, input logic [1:0] sel, input logic [31:0] a, input logic [31:0] b);
      logic [31:0] lo, hi, c, d;
      lo = edge_sel ? ~a : a;
      hi = edge_sel ? ~b : b;
      c = $urandom();
      d = $urandom();
      wr(FSI_ADR_CTRL, {24'h0, 1'b1, 3'h0, edge_sel, 3'h0});
      pm.step(a, b, 4);
      rd_chk(FSI_ADR_TEMP_LO, lo);
      rd_chk(FSI_ADR_TEMP_HI, hi);
      wr(FSI_ADR_CTRL, {24'h0, 1'b0, FSI_OP_ADD, 3'h0, sel});
      pm.step(c, d, 4);
      pm.step(c, d, 4);
      pm.pulse_c(4);
      chk(obs, calc(FSI_OP_ADD, 1'b0, (sel[0] ^ sel[1]) ? lo : c, sel[1] ? hi : d));
   endtask
   initial begin
      void'($urandom(32'h423c));
      repeat (3) @(posedge sys_clk);
      rst <= 1'b0;
      @(posedge sys_clk);
      wr(FSI_ADR_STATUS, 32'hffff_ffff);
      wr(8'h20, 32'hffff_ffff);
      // upper lanes only: the control byte must not move
      wb_sel <= 4'he;
      wr(FSI_ADR_CTRL, 32'hffff_ffff);
      wb_sel <= 4'hf;
      foreach (regs[i]) rd_chk(regs[i], 32'h0000_0000);
      $display("register test done");
      for (int i = 0; i < 16; i++) begin
         a = $urandom();
         b = (i < 4) ? a : $urandom();
         if (i == 5) begin
            a = 32'hffff_ffff;
            b = 32'h0000_0001;
         end
         run(i[1:0], i[2], i[3], a, b);
      end
      $display("operation test done");
      wr(FSI_ADR_IRQ_CLEAR, 32'h0000_0007);
      wr(FSI_ADR_CTRL, 32'h0000_0080);
      pm.step(a, b, 4);
      chk({34'h0, irq}, 35'h0);
      rd_chk(FSI_ADR_IRQ_STATUS, 32'h0000_0004);
      wr(FSI_ADR_IRQ_ENABLE, 32'h0000_0004);
      chk({34'h0, irq}, 35'h1);
      wr(FSI_ADR_IRQ_CLEAR, 32'h0000_0004);
      chk({34'h0, irq}, 35'h0);
      rd_chk(FSI_ADR_IRQ_ENABLE, 32'h0000_0004);
      rd_chk(FSI_ADR_IRQ_STATUS, 32'h0000_0000);
      $display("interrupt test done");
      for (int i = 0; i < 6; i++) temp_case(i[0], 2'(i / 2 + 1), $urandom(), $urandom());
      $display("temporary register test done");
      stop_test();
   end
endmodule
bind fsi_top fsi_top_checker #(.DATA_W(DATA_W)) chk_i (.sys_clk, .rst, .wb_cyc, .wb_stb, .wb_dat_r, .wb_ack,
   .master_clock, .result_register_clock, .input_bus_first, .input_bus_second, .operands_equal_or_zero,
   .first_greater_flag, .chained_exception_flag, .parity_first, .parity_second, .result_c, .irq);
